// *** hw/fram_defs.svh ***
// Constants for the serial nonvolatile memory access block.
// Assumes inclusion by bare name from hw/ design files.
`ifndef FRAM_DEFS_SVH
`define FRAM_DEFS_SVH
`define OP_ARM 8'h06
`define OP_DISARM 8'h04
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_READ 8'h03
`define OP_LAT_READ 8'h0b
`define OP_WRITE 8'h02
`define SR_GATE_BIT 7
`define SR_GUARD_HI_BIT 3
`define SR_GUARD_LO_BIT 2
`define SR_LATCH_BIT 1
`define SR_RESET 8'h00
`define ADDR_W 15
`define QUARTER_BASE 15'h6000
`define HALF_BASE 15'h4000
`endif

// *** hw/fram_pkg.sv ***
// Types for the serial nonvolatile memory access block.
// Assumes the constants header is compiled alongside.
package fram_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_RDATA = 3'b011,
    ST_WDATA = 3'b100,
    ST_STATW = 3'b101,
    ST_STATR = 3'b110,
    ST_IGNORE = 3'b111
  } phase_e;
  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_OTHER = 2'b10
  } cmd_e;
endpackage : fram_pkg

// *** hw/fram_fifo.sv ***
// Valid/ready FIFO with parameterised width and depth.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
module fram_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  wire [AW:0] fill = wrPtr_ff - rdPtr_ff;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  assign inReady = (fill != DEPTH[AW:0]);
  assign outValid = (fill != '0);
  assign outData = mem[rdPtr_ff[AW-1:0]];
  always_ff @(posedge clk) begin
    if (doPush) mem[wrPtr_ff[AW-1:0]] <= inData;
  end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doPush) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doPop) rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end
endmodule : fram_fifo

// *** hw/spi_fram_access_protect.sv ***
// Function
// - Status bits 0, 4, 5, 6 ignore writes and read as zero.
// - Status bit 1 shows the write latch flag, zero after power-up.
// - Only arm sets the latch flag; disarm, write and status write clear it.
// - Block guard bits are kept across power cycles.
// - Guard pair protects none, 6000h-7FFFh, 4000h-7FFFh or everything.
// - Array write needs latch set and address outside guarded range.
// - Status write blocked when gate enable is one and guard pin low.
// - Guard pin never blocks array writes.
// - Status read opcode shifts out one status byte.
// - Status write updates only gate enable and the two guard bits.
// - A completed status write clears the latch flag.
// - Write opcode, two address bytes, low 15 bits used.
// - Write data lands at consecutive addresses, wrapping 7FFFh to 0000h.
// - Each byte commits after its eighth bit; rising select ends write.
// - Burst reaching a guarded address stops and drops further bytes.
// - Read drives data after address, ignoring serial input.
// - Read bytes come from incrementing addresses, MSB first, with wrap.
// - Rising select ends a read and floats the output.
// - Latency read 0Bh has address, one dummy byte, then reads.
// - Latency read ignores input and ends with floating output.
// - Decode arm, disarm, status read/write, read and write opcodes.
// - Unknown opcode ignores input and floats output until next select.
// - Latch clears at select rise after disarm, status write, array write.
// - Sample on rising serial clock, change output on falling, MSB first.
// Slave-side command logic of a 32K x 8 serial nonvolatile memory.
// Assumes serial pins are asynchronous to clk, which runs far faster than the serial clock.
`timescale 1ns/100ps
`include "fram_defs.svh"
module spi_fram_access_protect #(
  parameter int DEPTH = 32768,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic selectN,
  input wire logic serClk,
  input wire logic serIn,
  output logic serOut,
  output logic serOutEnN,
  input wire logic guardPinN,
  output logic [7:0] statusView,
  output logic writeStall
);
  logic [2:0] csSync_ff;
  logic [2:0] sckSync_ff;
  logic [1:0] siSync_ff;
  logic [1:0] wpSync_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      csSync_ff <= 3'h7;
      sckSync_ff <= 3'h0;
      siSync_ff <= 2'h0;
      wpSync_ff <= 2'h3;
    end else begin
      csSync_ff <= {csSync_ff[1:0], selectN};
      sckSync_ff <= {sckSync_ff[1:0], serClk};
      siSync_ff <= {siSync_ff[0], serIn};
      wpSync_ff <= {wpSync_ff[0], guardPinN};
    end
  end
  // Edge detectors read only the second and third stages.
  wire csLow = ~csSync_ff[1];
  wire csFall = ~csSync_ff[1] & csSync_ff[2];
  wire csRise = csSync_ff[1] & ~csSync_ff[2];
  wire sckRise = csLow & sckSync_ff[1] & ~sckSync_ff[2];
  wire sckFall = csLow & ~sckSync_ff[1] & sckSync_ff[2];
  wire siBit = siSync_ff[1];
  wire wpHigh = wpSync_ff[1];

  // The array is the nonvolatile store; a reset of clk does not touch it.
  logic [7:0] array [DEPTH];
  logic gate_ff = 1'b0;
  logic guardHi_ff = 1'b0;
  logic guardLo_ff = 1'b0;
  logic latch_ff;
  logic [7:0] stat;
  assign stat = {gate_ff, 3'h0, guardHi_ff, guardLo_ff, latch_ff, 1'b0};
  assign statusView = stat;

  fram_pkg::phase_e phase_ff;
  fram_pkg::phase_e nxt_phase;
  fram_pkg::cmd_e cmd_ff;
  logic [7:0] shIn_ff;
  logic [2:0] bitCnt_ff;
  logic addrByte_ff;
  logic [`ADDR_W-1:0] addr_ff;
  logic [7:0] shOut_ff;
  logic outEn_ff;
  logic burstStop_ff;
  logic clearLatch_ff;

  wire [7:0] rxByte = {shIn_ff[6:0], siBit};
  wire byteDone = sckRise && (bitCnt_ff == 3'h7);
  wire [`ADDR_W-1:0] addrNext = addr_ff + 1'b1;

  function automatic logic guarded(input logic hi, input logic lo,
                                   input logic [`ADDR_W-1:0] a);
    case ({hi, lo})
      2'b00: guarded = 1'b0;
      2'b01: guarded = (a >= `QUARTER_BASE);
      2'b10: guarded = (a >= `HALF_BASE);
      default: guarded = 1'b1;
    endcase
  endfunction : guarded

  // Guard pin is deliberately absent from the array write condition.
  wire addrGuarded = guarded(guardHi_ff, guardLo_ff, addr_ff);
  wire arrayWrOk = latch_ff && !addrGuarded && !burstStop_ff;
  wire statWrOk = latch_ff && !(gate_ff && !wpHigh);

  // Write bytes pass through a FIFO; the array port drains it each cycle.
  logic fifoInReady;
  logic fifoOutValid;
  logic [22:0] fifoOutData;
  wire pushWr = (phase_ff == fram_pkg::ST_WDATA) && byteDone && arrayWrOk;
  fram_fifo #(.WIDTH(23), .DEPTH(FIFO_DEPTH)) wrFifo (
    .clk(clk),
    .rst(rst),
    .flush(1'b0),
    .inValid(pushWr),
    .inReady(fifoInReady),
    .inData({addr_ff, rxByte}),
    .outValid(fifoOutValid),
    .outReady(1'b1),
    .outData(fifoOutData)
  );
  assign writeStall = ~fifoInReady;
  always_ff @(posedge clk) begin
    if (fifoOutValid) array[fifoOutData[22:8]] <= fifoOutData[7:0];
  end

  always_comb begin
    nxt_phase = phase_ff;
    if (byteDone) begin
      unique case (phase_ff)
        fram_pkg::ST_OPCODE: begin
          unique case (rxByte)
            `OP_READ, `OP_LAT_READ, `OP_WRITE: nxt_phase = fram_pkg::ST_ADDR;
            `OP_STAT_RD: nxt_phase = fram_pkg::ST_STATR;
            `OP_STAT_WR: nxt_phase = fram_pkg::ST_STATW;
            `OP_ARM, `OP_DISARM: nxt_phase = fram_pkg::ST_IGNORE;
            default: nxt_phase = fram_pkg::ST_IGNORE;
          endcase
        end
        fram_pkg::ST_ADDR: begin
          if (addrByte_ff) begin
            if (cmd_ff == fram_pkg::CMD_WRITE) nxt_phase = fram_pkg::ST_WDATA;
            else if (cmd_ff == fram_pkg::CMD_OTHER) nxt_phase = fram_pkg::ST_DUMMY;
            else nxt_phase = fram_pkg::ST_RDATA;
          end
        end
        fram_pkg::ST_DUMMY: nxt_phase = fram_pkg::ST_RDATA;
        fram_pkg::ST_STATR: nxt_phase = fram_pkg::ST_IGNORE;
        fram_pkg::ST_STATW: nxt_phase = fram_pkg::ST_IGNORE;
        fram_pkg::ST_RDATA: nxt_phase = fram_pkg::ST_RDATA;
        fram_pkg::ST_WDATA: nxt_phase = fram_pkg::ST_WDATA;
        fram_pkg::ST_IGNORE: nxt_phase = fram_pkg::ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || csFall || !csLow) begin
      phase_ff <= fram_pkg::ST_OPCODE;
      bitCnt_ff <= 3'h0;
      addrByte_ff <= 1'b0;
      shIn_ff <= 8'h00;
      burstStop_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      if (sckRise) begin
        bitCnt_ff <= bitCnt_ff + 3'h1;
        shIn_ff <= rxByte;
      end
      if (byteDone && phase_ff == fram_pkg::ST_ADDR) addrByte_ff <= 1'b1;
      if (byteDone && phase_ff == fram_pkg::ST_WDATA && !arrayWrOk) begin
        burstStop_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ff <= fram_pkg::CMD_OTHER;
      addr_ff <= '0;
    end else if (byteDone) begin
      if (phase_ff == fram_pkg::ST_OPCODE) begin
        if (rxByte == `OP_WRITE) cmd_ff <= fram_pkg::CMD_WRITE;
        else if (rxByte == `OP_LAT_READ) cmd_ff <= fram_pkg::CMD_OTHER;
        else cmd_ff <= fram_pkg::CMD_READ;
      end
      if (phase_ff == fram_pkg::ST_ADDR && !addrByte_ff) begin
        addr_ff <= {rxByte[6:0], 8'h00};
      end
      if (phase_ff == fram_pkg::ST_ADDR && addrByte_ff) begin
        addr_ff <= {addr_ff[14:8], rxByte};
      end
      if (phase_ff == fram_pkg::ST_WDATA && arrayWrOk) addr_ff <= addrNext;
      if (phase_ff == fram_pkg::ST_RDATA) addr_ff <= addrNext;
    end
  end

  // Status fields; guard bits model nonvolatile cells and survive rst.
  always_ff @(posedge clk) begin
    if (byteDone && phase_ff == fram_pkg::ST_STATW && statWrOk) begin
      gate_ff <= rxByte[`SR_GATE_BIT];
      guardHi_ff <= rxByte[`SR_GUARD_HI_BIT];
      guardLo_ff <= rxByte[`SR_GUARD_LO_BIT];
    end
  end
  wire opMarksClear = (phase_ff == fram_pkg::ST_OPCODE) && byteDone &&
                      ((rxByte == `OP_DISARM) || (rxByte == `OP_WRITE));
  wire statMarksClear = (phase_ff == fram_pkg::ST_STATW) && byteDone;
  always_ff @(posedge clk) begin
    if (rst || csFall) clearLatch_ff <= 1'b0;
    else if (opMarksClear || statMarksClear) clearLatch_ff <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) latch_ff <= 1'(`SR_RESET >> `SR_LATCH_BIT);
    else if (csRise && clearLatch_ff) latch_ff <= 1'b0;
    else if (byteDone && phase_ff == fram_pkg::ST_OPCODE && rxByte == `OP_ARM) begin
      latch_ff <= 1'b1;
    end
  end

  // Read bytes load on the falling edge that starts them, so in mode 3 the output
  // never moves while the serial clock is still high.
  wire loadStat = byteDone && phase_ff == fram_pkg::ST_OPCODE && rxByte == `OP_STAT_RD;
  wire loadRead = sckFall && (phase_ff == fram_pkg::ST_RDATA) && (bitCnt_ff == 3'h0);
  always_ff @(posedge clk) begin
    if (rst || !csLow) begin
      shOut_ff <= 8'h00;
      outEn_ff <= 1'b0;
    end else begin
      if (loadStat) shOut_ff <= stat;
      else if (loadRead) shOut_ff <= array[addr_ff];
      else if (sckFall && (phase_ff == fram_pkg::ST_RDATA ||
               phase_ff == fram_pkg::ST_STATR) && bitCnt_ff != 3'h0) begin
        shOut_ff <= {shOut_ff[6:0], 1'b0};
      end
      if (sckFall) begin
        outEn_ff <= phase_ff == fram_pkg::ST_RDATA || phase_ff == fram_pkg::ST_STATR;
      end
    end
  end
  assign serOut = shOut_ff[7];
  assign serOutEnN = ~outEn_ff;
endmodule : spi_fram_access_protect

// *** verif/spi_fram_props.sv ***
// Assertions on the serial memory block's pins and status view.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module spi_fram_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic selectN,
  input wire logic serClk,
  input wire logic serIn,
  input wire logic serOut,
  input wire logic serOutEnN,
  input wire logic guardPinN,
  input wire logic [7:0] statusView,
  input wire logic writeStall
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_fixed_zero: assert property (statusView[6:4] == 3'h0 && !statusView[0])
    else $error("fixed status bits set");
  chk_latch_reset: assert property ($fell(rst) |-> !statusView[1])
    else $error("latch set after reset");
  chk_idle_hold: assert property (selectN [*6] |=> $stable(statusView))
    else $error("status changed while idle");
  chk_gate_block: assert property ($changed(statusView[7:2]) |->
    !($past(statusView[7]) && !$past(guardPinN)))
    else $error("guarded status write taken");
  chk_latch_drop: assert property ($changed(statusView[7:2]) |->
    ##[0:40] !statusView[1])
    else $error("latch kept after status write");
  chk_out_edge: assert property (!serOutEnN && !$past(serOutEnN) && $changed(serOut)
    |-> !serClk)
    else $error("output moved while serial clock high");
  chk_en_frame: assert property (!serOutEnN |-> !$past(selectN, 6))
    else $error("output driven outside frame");
  chk_no_stall: assert property (!writeStall)
    else $error("write path stalled");
  cover property ($fell(serOutEnN));
  cover property ($rose(statusView[1]));
  cover property ($changed(statusView[7:2]));
endmodule : spi_fram_props
bind spi_fram_access_protect spi_fram_props spi_fram_props_i (
  .clk(clk),
  .rst(rst),
  .selectN(selectN),
  .serClk(serClk),
  .serIn(serIn),
  .serOut(serOut),
  .serOutEnN(serOutEnN),
  .guardPinN(guardPinN),
  .statusView(statusView),
  .writeStall(writeStall)
);

// *** verif/spi_master_model.sv ***
// Behavioural mode 0 or mode 3 bus master driving the memory's serial pins.
// Assumes clk runs eight times faster than the serial clock it makes.
`timescale 1ns/100ps
module spi_master_model (
  input wire logic clk,
  output logic selectN,
  output logic serClk,
  output logic serIn,
  output logic guardPinN,
  input wire logic serOut,
  input wire logic serOutEnN
);
  logic [7:0] buf8 [4];
  logic seenEn;
  logic mode3;
  initial begin
    mode3 = 1'b0;
    selectN = 1'b1;
    serClk = 1'b0;
    serIn = 1'b0;
    guardPinN = 1'b1;
    seenEn = 1'b0;
  end
  always @(posedge clk) begin
    if (!serOutEnN) seenEn <= 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (mode3) serClk <= 1'b0;
      serIn <= tx[i];
      tick(4);
      rx[i] = serOut;
      serClk <= 1'b1;
      tick(4);
      if (!mode3) serClk <= 1'b0;
    end
  endtask : xfer
  // Idle clock level picks the mode; it only changes while deselected.
  task automatic mode(input logic m);
    mode3 = m;
    serClk <= m;
    tick(8);
  endtask : mode
  task automatic sel();
    selectN <= 1'b0;
    seenEn = 1'b0;
    tick(4);
  endtask : sel
  // The data line is inverted when released so a stale bit cannot pass for a driven one.
  task automatic desel();
    tick(4);
    selectN <= 1'b1;
    serIn <= ~serIn;
    tick(8);
  endtask : desel
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    sel();
    xfer(op, r);
    desel();
  endtask : cmd
  task automatic mem(input logic [7:0] op, input logic [15:0] a, input int n);
    logic [7:0] r;
    sel();
    xfer(op, r);
    xfer(a[15:8], r);
    xfer(a[7:0], r);
    if (op == 8'h0b) xfer(8'h00, r);
    for (int i = 0; i < n; i++) begin
      xfer(buf8[i], r);
      if (op != 8'h02) buf8[i] = r;
    end
    desel();
  endtask : mem
  task automatic stat();
    sel();
    xfer(8'h05, buf8[0]);
    xfer(8'hff, buf8[0]);
    desel();
  endtask : stat
  task automatic status_write_cmd(input logic [7:0] v);
    cmd(8'h06);
    sel();
    xfer(8'h01, buf8[3]);
    xfer(v, buf8[3]);
    desel();
  endtask : status_write_cmd
endmodule : spi_master_model

// *** verif/spi_fram_access_protect_test.sv ***
// Self-checking bench for the serial memory command and protection logic.
// Assumes the master model and the checker bind are compiled with it.
`timescale 1ns/100ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin nFail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module spi_fram_access_protect_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic selectN, serClk, serIn, guardPinN, serOut, serOutEnN, writeStall;
  logic [7:0] statusView;
  int nFail = 0;
  int nCompared = 0;
  always #25 clk = ~clk;
  spi_fram_access_protect spi_fram_access_protect_i (
    .clk(clk),
    .rst(rst),
    .selectN(selectN),
    .serClk(serClk),
    .serIn(serIn),
    .serOut(serOut),
    .serOutEnN(serOutEnN),
    .guardPinN(guardPinN),
    .statusView(statusView),
    .writeStall(writeStall)
  );
  spi_master_model bus (
    .clk(clk),
    .selectN(selectN),
    .serClk(serClk),
    .serIn(serIn),
    .guardPinN(guardPinN),
    .serOut(serOut),
    .serOutEnN(serOutEnN)
  );
  task automatic reportAndStop();
    $display("compared %0d mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : reportAndStop
  task automatic st(input logic [7:0] e);
    bus.stat();
    `CHK(bus.buf8[0], e)
    `CHK(statusView, e)
  endtask : st
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus.tick(4);
    st(8'h00);
    bus.cmd(8'h06);
    bus.buf8[0] = 8'h5a;
    bus.mem(8'h02, 16'h6000, 1);
    bus.cmd(8'h06);
    bus.buf8 = '{8'ha0, 8'ha1, 8'ha2, 8'h00};
    bus.mem(8'h02, 16'hfffe, 3);
    st(8'h00);
    bus.mem(8'h03, 16'h7ffe, 3);
    `CHK(bus.buf8[0], 8'ha0)
    `CHK(bus.buf8[2], 8'ha2)
    `CHK(serOutEnN, 1'b1)
    bus.buf8[0] = 8'h11;
    bus.mem(8'h02, 16'h7fff, 1);
    bus.mem(8'h0b, 16'h7fff, 2);
    `CHK(bus.buf8[0], 8'ha1)
    `CHK(bus.buf8[1], 8'ha2)
    `CHK(serOutEnN, 1'b1)
    bus.cmd(8'h06);
    bus.mem(8'h0b, 16'h0000, 1);
    `CHK(bus.buf8[0], 8'ha2)
    st(8'h02);
    bus.cmd(8'h04);
    st(8'h00);
    bus.status_write_cmd(8'hff);
    st(8'h8c);
    bus.cmd(8'h06);
    bus.buf8[0] = 8'h33;
    bus.mem(8'h02, 16'h0000, 1);
    bus.mem(8'h03, 16'h0000, 1);
    `CHK(bus.buf8[0], 8'ha2)
    bus.status_write_cmd(8'h84);
    bus.guardPinN <= 1'b0;
    bus.status_write_cmd(8'h00);
    st(8'h84);
    bus.cmd(8'h06);
    bus.buf8 = '{8'h11, 8'h12, 8'h13, 8'h14};
    bus.mem(8'h02, 16'h5ffe, 4);
    bus.mem(8'h03, 16'h5ffe, 3);
    `CHK(bus.buf8[1], 8'h12)
    `CHK(bus.buf8[2], 8'h5a)
    bus.guardPinN <= 1'b1;
    bus.status_write_cmd(8'h00);
    bus.guardPinN <= 1'b0;
    bus.status_write_cmd(8'h08);
    st(8'h08);
    bus.cmd(8'h06);
    rst <= 1'b1;
    bus.tick(2);
    rst <= 1'b0;
    bus.tick(4);
    st(8'h08);
    bus.cmd(8'h06);
    bus.buf8 = '{8'h55, 8'h66, 8'h00, 8'h00};
    bus.mem(8'h02, 16'h3fff, 2);
    bus.mem(8'h03, 16'h3fff, 2);
    `CHK(bus.buf8[0], 8'h55)
    `CHK(bus.buf8[1] === 8'h66, 1'b0)
    bus.mode(1'b1);
    bus.cmd(8'h06);
    bus.buf8[0] = 8'h77;
    bus.mem(8'h02, 16'h1000, 1);
    bus.mem(8'h03, 16'h1000, 1);
    `CHK(bus.buf8[0], 8'h77)
    st(8'h08);
    bus.mode(1'b0);
    bus.mem(8'hc3, 16'h0500, 2);
    `CHK(bus.seenEn, 1'b0)
    st(8'h08);
    reportAndStop();
  end
  // The whole sequence needs about 8000 cycles, so this only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    reportAndStop();
  end
endmodule : spi_fram_access_protect_test
